/* core/ots_top.sv */
/*
  Oscillator trim and spread-spectrum control: Avalon-MM register
  slave, coarse band and fine trim to the fast oscillator with an
  optional triangular sweep, and slow oscillator trim with its
  divide-by-four time base.
  Assumes CLK_I is the fast oscillator clock as seen by the digital
  core, STANDBY_I mirrors stop/sleep, and the slow oscillator level
  arrives synchronous to CLK_I.
*/
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
module ots_top import ots_pkg::*; (
  // clock and reset
  input  wire logic              CLK_I,
  input  wire logic              RST_N_I,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] AVS_ADDRESS_I,
  input  wire logic              AVS_READ_I,
  input  wire logic              AVS_WRITE_I,
  input  wire logic [31:0]       AVS_WRITEDATA_I,
  input  wire logic [3:0]        AVS_BYTEENABLE_I,
  output logic [31:0]            AVS_READDATA_O,
  output logic                   AVS_WAITREQUEST_O,
  // power state
  input  wire logic              STANDBY_I,
  // fast oscillator control
  output logic [1:0]             COARSE_BAND_O,
  output logic                   HIGH_BAND_O,
  output logic [7:0]             SWEPT_TRIM_O,
  output logic                   SPREAD_EN_O,
  output logic                   FAST_OSC_RUN_O,
  // slow oscillator
  input  wire logic              SLOW_OSC_I,
  output logic [4:0]             SLOW_TRIM_O,
  output logic                   SLOW_TB_O
);

  // software-visible state
  logic [7:0]  coarse_sweep_ctrl;  // rate, amplitude, band
  logic [7:0]  fine_trim_code;     // higher value, lower frequency
  logic [4:0]  slow_trim_code;     // higher value, higher frequency

  // bus handshake state
  logic        ack;                // one wait state has passed
  logic [31:0] rdata;              // registered read data

  // oscillator run state
  logic        fast_run;           // oscillator enabled

  // derived control fields
  logic [3:0]  sweep_rate_code;
  logic [1:0]  sweep_amplitude_code;
  logic [1:0]  coarse_band_code;
  logic [7:0]  swept_trim_output;
  logic        slow_tb;

  // byte address of each register
  localparam logic [ADDR_W-1:0] A_COARSE = {IDX_COARSE, 2'b00};
  localparam logic [ADDR_W-1:0] A_FINE   = {IDX_FINE, 2'b00};
  localparam logic [ADDR_W-1:0] A_SLOW   = {IDX_SLOW, 2'b00};
  localparam logic [ADDR_W-1:0] A_STATUS = {IDX_STATUS, 2'b00};

  // request decode
  wire req      = AVS_READ_I | AVS_WRITE_I;
  wire take     = req & ack;           // the edge that completes
  wire wr_take  = AVS_WRITE_I & ack;
  wire lane0    = AVS_BYTEENABLE_I[0];
  wire lane1    = AVS_BYTEENABLE_I[1];
  wire hit_c    = (AVS_ADDRESS_I == A_COARSE);
  wire hit_f    = (AVS_ADDRESS_I == A_FINE);
  wire hit_s    = (AVS_ADDRESS_I == A_SLOW);
  wire hit_st   = (AVS_ADDRESS_I == A_STATUS);

  // write strobes; only the low byte lane carries the 8-bit fields
  wire we_c     = wr_take & hit_c & lane0;
  wire we_f     = wr_take & hit_f & lane0;
  wire we_s     = wr_take & hit_s & lane0;

  // field split of the coarse/sweep control register
  assign sweep_rate_code      = coarse_sweep_ctrl[RATE_LSB +: 4];
  assign sweep_amplitude_code = coarse_sweep_ctrl[AMP_LSB +: 2];
  assign coarse_band_code     = coarse_sweep_ctrl[BAND_LSB +: 2];

  // read selection; unmapped addresses read zero
  wire [31:0] rd_c  = {24'h000000, coarse_sweep_ctrl};
  wire [31:0] rd_f  = {24'h000000, fine_trim_code};
  wire [31:0] rd_s  = {27'h0000000, slow_trim_code};
  wire [31:0] rd_st = {21'h000000, slow_tb, fast_run,
                       SPREAD_EN_O, swept_trim_output};
  wire [31:0] rd_mux = hit_c  ? rd_c  :
                       hit_f  ? rd_f  :
                       hit_s  ? rd_s  :
                       hit_st ? rd_st : 32'h00000000;

  // a request is held one cycle, then released on the next edge;
  // the fixed wait state keeps read data a clean flop output
  assign AVS_WAITREQUEST_O = req & ~ack;

  // wait-state flop: set in the first cycle of a request, cleared
  // when the master completes at the edge that samples it low
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I)
      ack <= 1'b0;
    else
      ack <= req & ~ack;
  end

  // read data captured while the master waits, so it stands at the
  // completing edge
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I)
      rdata <= 32'h00000000;
    else if (AVS_READ_I & ~ack)
      rdata <= rd_mux;
  end
  assign AVS_READDATA_O = rdata;

  // coarse/sweep control register
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I)
      coarse_sweep_ctrl <= COARSE_RST;                  // [RULE_11]
    else if (we_c)
      coarse_sweep_ctrl <= AVS_WRITEDATA_I[7:0];        // [RULE_11]
  end

  // fine trim register; the sweep adds to this value
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I)
      fine_trim_code <= FINE_RST;                       // [RULE_10]
    else if (we_f)
      fine_trim_code <= AVS_WRITEDATA_I[7:0];           // [RULE_10]
  end

  // slow trim register; bits 7:5 are not stored and read zero
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I)
      slow_trim_code <= SLOW_RST;                       // [RULE_13]
    else if (we_s)
      slow_trim_code <= AVS_WRITEDATA_I[4:0];           // [RULE_13]
  end

  // the oscillator stops on entry to stop/sleep and restarts on wake;
  // the sweep state is frozen rather than reset so it resumes where
  // it left off
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I)
      fast_run <= 1'b1;
    else
      fast_run <= ~STANDBY_I;                           // [RULE_08]
  end

  // sweep generator drives the trim to the oscillator core
  ots_sweep_gen #(
    .RATE_W     (4)
  ) u_sweep (
    .clk_i      (CLK_I),
    .rst_n_i    (RST_N_I),
    .run_i      (fast_run),
    .rate_i     (sweep_rate_code),
    .amp_code_i (sweep_amplitude_code),
    .fine_i     (fine_trim_code),
    .trim_o     (swept_trim_output)
  );

  // the slow oscillator never stops, so its divider ignores standby
  ots_slow_div u_slow (
    .clk_i      (CLK_I),
    .rst_n_i    (RST_N_I),
    .osc_i      (SLOW_OSC_I),
    .tb_o       (slow_tb)
  );

  // spread status and band selection, registered for clean outputs
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SPREAD_EN_O   <= 1'b0;
      COARSE_BAND_O <= COARSE_RST[1:0];
      HIGH_BAND_O   <= COARSE_RST[1];
    end else begin
      SPREAD_EN_O   <= (sweep_rate_code != 4'h0);       // [RULE_01]
      COARSE_BAND_O <= coarse_band_code;                // [RULE_09]
      HIGH_BAND_O   <= coarse_band_code[1];             // [RULE_09]
    end
  end

  // direct drives from flops
  assign SWEPT_TRIM_O   = swept_trim_output;
  assign FAST_OSC_RUN_O = fast_run;
  assign SLOW_TRIM_O    = slow_trim_code;
  assign SLOW_TB_O      = slow_tb;

  bus_wait_a: assert property (  // [RULE_11]
    @(posedge CLK_I) disable iff (!RST_N_I)
    (req && !ack) |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O)
    else $error("wait state not exactly one cycle");
  coarse_wr_a: assert property (  // [RULE_11]
    @(posedge CLK_I) disable iff (!RST_N_I)
    we_c |=> coarse_sweep_ctrl == $past(AVS_WRITEDATA_I[7:0]))
    else $error("coarse register not written");
  band_out_a: assert property (  // [RULE_09]
    @(posedge CLK_I) disable iff (!RST_N_I)
    we_c ##1 1'b1 |=> HIGH_BAND_O == coarse_sweep_ctrl[1])
    else $error("band select not followed");
  slow_wr_a: assert property (  // [RULE_13]
    @(posedge CLK_I) disable iff (!RST_N_I)
    we_s |=> SLOW_TRIM_O == $past(AVS_WRITEDATA_I[4:0]))
    else $error("slow trim not written");
  run_stop_a: assert property (  // [RULE_08]
    @(posedge CLK_I) disable iff (!RST_N_I)
    STANDBY_I |=> !FAST_OSC_RUN_O)
    else $error("oscillator not halted in standby");

  // read path: data captured in the wait cycle stand at completion
  rd_data_a: assert property (  // [RULE_11]
    @(posedge CLK_I) disable iff (!RST_N_I)
    (AVS_READ_I && ack) |-> AVS_READDATA_O == $past(rd_mux))
    else $error("read data not held at completion");
  // unmapped addresses read zero, so software sees no stale data
  rd_unmap_a: assert property (  // [RULE_11]
    @(posedge CLK_I) disable iff (!RST_N_I)
    (AVS_READ_I && !ack && !hit_c && !hit_f && !hit_s && !hit_st)
      |=> AVS_READDATA_O == 32'h00000000)
    else $error("unmapped read not zero");
  // coarse register reads back whole, upper lanes zero
  rd_coarse_a: assert property (  // [RULE_11]
    @(posedge CLK_I) disable iff (!RST_N_I)
    (AVS_READ_I && !ack && hit_c)
      |=> AVS_READDATA_O[7:0] == $past(coarse_sweep_ctrl)
       && AVS_READDATA_O[31:8] == 24'h000000)
    else $error("coarse read back wrong");
  // slow trim reads back five bits, the unused bits as zero
  rd_slow_a: assert property (  // [RULE_13]
    @(posedge CLK_I) disable iff (!RST_N_I)
    (AVS_READ_I && !ack && hit_s)
      |=> AVS_READDATA_O[4:0] == $past(slow_trim_code)
       && AVS_READDATA_O[31:5] == 27'h0000000)
    else $error("slow trim read back wrong");
  // status shows the run state and nothing above the time base bit
  rd_status_a: assert property (  // [RULE_08]
    @(posedge CLK_I) disable iff (!RST_N_I)
    (AVS_READ_I && !ack && hit_st)
      |=> AVS_READDATA_O[9] == $past(fast_run)
       && AVS_READDATA_O[31:11] == 21'h00000)
    else $error("status read back wrong");
  // fine trim takes the low byte at the completing edge
  fine_wr_a: assert property (  // [RULE_10]
    @(posedge CLK_I) disable iff (!RST_N_I)
    we_f |=> fine_trim_code == $past(AVS_WRITEDATA_I[7:0]))
    else $error("fine trim not written");
  // a write without the low lane must not touch any field
  lane_off_a: assert property (  // [RULE_11]
    @(posedge CLK_I) disable iff (!RST_N_I)
    (wr_take && !lane0) |=> $stable(coarse_sweep_ctrl)
      && $stable(fine_trim_code) && $stable(slow_trim_code))
    else $error("write without low lane changed a register");
  // the status word is read-only; a write to it is dropped
  status_wr_a: assert property (  // [RULE_11]
    @(posedge CLK_I) disable iff (!RST_N_I)
    (wr_take && hit_st) |=> $stable(coarse_sweep_ctrl)
      && $stable(fine_trim_code) && $stable(slow_trim_code))
    else $error("status write changed a register");
  // registers only move at a completing write
  idle_keep_a: assert property (  // [RULE_10]
    @(posedge CLK_I) disable iff (!RST_N_I)
    !wr_take |=> $stable(coarse_sweep_ctrl)
      && $stable(fine_trim_code) && $stable(slow_trim_code))
    else $error("register changed without a write");
  // the oscillator restarts one clock after wake
  run_wake_a: assert property (  // [RULE_08]
    @(posedge CLK_I) disable iff (!RST_N_I)
    !STANDBY_I |=> FAST_OSC_RUN_O)
    else $error("oscillator not resumed on wake");
  // a stopped oscillator has no clock, so the trim must not move
  trim_freeze_a: assert property (  // [RULE_08]
    @(posedge CLK_I) disable iff (!RST_N_I)
    !FAST_OSC_RUN_O |=> $stable(SWEPT_TRIM_O))
    else $error("trim moved while halted");
  // rate code zero passes the fine trim straight through
  fixed_top_a: assert property (  // [RULE_01]
    @(posedge CLK_I) disable iff (!RST_N_I)
    (sweep_rate_code == 4'h0 && fast_run)
      |=> SWEPT_TRIM_O == $past(fine_trim_code))
    else $error("trim not fixed at rate code zero");
  // the spread flag follows the rate code one clock later
  spread_flag_a: assert property (  // [RULE_01]
    @(posedge CLK_I) disable iff (!RST_N_I)
    1'b1 |=> SPREAD_EN_O == ($past(sweep_rate_code) != 4'h0))
    else $error("spread flag does not follow rate code");
  // band outputs follow the coarse field one clock later
  band_follow_a: assert property (  // [RULE_09]
    @(posedge CLK_I) disable iff (!RST_N_I)
    1'b1 |=> COARSE_BAND_O == $past(coarse_band_code)
      && HIGH_BAND_O == $past(coarse_band_code[1]))
    else $error("band outputs do not follow coarse field");
endmodule : ots_top

/* core/ots_pkg.sv */
/*
  Constants shared by the oscillator trim and spread-spectrum block:
  register indices, field positions, reset values and sweep constants.
  Assumes a 32-bit Avalon-MM slave whose byte address is four times
  the register index.
*/
// What this block does
// RULE_01 - rate code zero gives fixed, unswept trim
// RULE_02 - amplitude code picks peak 4, 8, 16, 32
// RULE_03 - swept trim stays within fine trim +/- amplitude
// RULE_04 - sweep offset advances every rate-code cycles; here it moves on every second update, every 2*rate cycles
// RULE_05 - full sweep lasts 4*rate*(2*amp+1) cycles
// RULE_06 - swept trim saturates at 0 and 255
// RULE_07 - software keeps fine trim inside unclipped range
// RULE_08 - fast oscillator and sweep halt in standby
// RULE_09 - coarse band code selects 16 or 32 MHz
// RULE_10 - fine trim lowers frequency, resets to 0x80
// RULE_11 - coarse register resets 0x01, fields 7:4,3:2,1:0
// RULE_12 - slow oscillator divided by four gives time base
// RULE_13 - slow trim five bits, resets 0x10
// RULE_14 - software may calibrate slow trim against fast
// RULE_15 - offset ramps one code per step, triangular
package ots_pkg;
  // register indices; byte address is index times four
  localparam logic [15:0] IDX_COARSE = 16'hA001;
  localparam logic [15:0] IDX_FINE   = 16'hA002;
  localparam logic [15:0] IDX_SLOW   = 16'hA007;
  localparam logic [15:0] IDX_STATUS = 16'hA008;
  localparam int          ADDR_W     = 18;
  // reset values
  localparam logic [7:0]  COARSE_RST = 8'h01;
  localparam logic [7:0]  FINE_RST   = 8'h80;
  localparam logic [4:0]  SLOW_RST   = 5'h10;
  // field positions in the coarse/sweep control register
  localparam int          RATE_LSB   = 4;
  localparam int          AMP_LSB    = 2;
  localparam int          BAND_LSB   = 0;
  // status register field positions
  localparam int          ST_SPREAD  = 8;
  localparam int          ST_RUN     = 9;
  localparam int          ST_TB      = 10;
  // smallest sweep amplitude; each code step doubles it
  localparam logic [5:0]  AMP_BASE   = 6'h04;
  // trim saturation limits
  localparam logic [7:0]  TRIM_MIN   = 8'h00;
  localparam logic [7:0]  TRIM_MAX   = 8'hFF;
  // value of half at which a slow oscillator rising edge toggles the time base
  localparam logic        SLOW_HALF  = 1'b1;
endpackage : ots_pkg

/* core/ots_slow_div.sv */
/*
  Divide-by-four of the slow oscillator into the low-speed time base.
  Assumes the slow oscillator level is synchronous to CLK_I and much
  slower than it.
*/
`timescale 1ns/1ps
module ots_slow_div import ots_pkg::*; (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // slow oscillator level and divided time base
  input  wire logic osc_i,
  output logic      tb_o
);
  logic osc_q;   // previous oscillator level
  logic half;    // counts rising edges within a half period
  wire  rise = osc_i & ~osc_q;

  // toggle every second rising edge: period is four oscillator periods
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_q <= 1'b0;
      half  <= 1'b0;
      tb_o  <= 1'b0;
    end else begin
      osc_q <= osc_i;
      if (rise) begin
        half <= ~half;
        if (half == SLOW_HALF)
          tb_o <= ~tb_o;   // [RULE_12]
      end
    end
  end

  tb_toggle_a: assert property (  // [RULE_12]
    @(posedge clk_i) disable iff (!rst_n_i)
    (rise && half) |=> (tb_o != $past(tb_o)))
    else $error("time base missed its toggle");
  tb_hold_a: assert property (  // [RULE_12]
    @(posedge clk_i) disable iff (!rst_n_i)
    (!rise || !half) |=> $stable(tb_o))
    else $error("time base toggled early");
endmodule : ots_slow_div

/* core/ots_sweep_gen.sv */
/*
  Triangular sweep generator adding a bounded offset to the fine trim
  code, saturated to the 8-bit trim range.
  Assumes clk_i is the fast oscillator clock and run_i is low while
  the processor is in stop or sleep.
*/
`timescale 1ns/1ps
module ots_sweep_gen import ots_pkg::*; #(
  parameter int RATE_W = 4
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // control
  input  wire logic              run_i,
  input  wire logic [RATE_W-1:0] rate_i,
  input  wire logic [1:0]        amp_code_i,
  input  wire logic [7:0]        fine_i,
  // swept trim to the oscillator
  output logic [7:0]             trim_o
);
  logic [RATE_W-1:0] tick_cnt;  // cycles since last update
  logic              half;      // second update of a step pair
  logic              dir_up;    // ramp direction
  logic signed [6:0] offset;    // current offset, -32..32
  logic [7:0]        next_trim;

  wire spread_on = (rate_i != '0);                           // [RULE_01]
  wire tick = spread_on && run_i
              && (tick_cnt == rate_i - 1'b1);                // [RULE_04]
  wire [5:0] amp = AMP_BASE << amp_code_i;                   // [RULE_02]
  wire signed [6:0] amp_s = $signed({1'b0, amp});
  wire at_top = (offset >= amp_s);
  wire at_bot = (offset <= -amp_s);
  wire signed [9:0] sum = $signed({2'b00, fine_i})
                          + {{3{offset[6]}}, offset};        // [RULE_03]
  wire low  = sum < 10'sd0;
  wire high = sum > $signed({2'b00, TRIM_MAX});

  // saturate rather than wrap
  always_comb begin
    if (!spread_on)
      next_trim = fine_i;                                    // [RULE_01]
    else if (low)
      next_trim = TRIM_MIN;                                  // [RULE_06]
    else if (high)
      next_trim = TRIM_MAX;                                  // [RULE_06]
    else
      next_trim = sum[7:0];                                  // [RULE_03]
  end

  // the offset moves on every second update and dwells one step pair
  // at each peak, so a full sweep is 4*(2*amp+1) updates
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt <= '0;
      half     <= 1'b0;
      dir_up   <= 1'b1;
      offset   <= '0;
    end else if (!spread_on) begin
      tick_cnt <= '0;
      half     <= 1'b0;
      dir_up   <= 1'b1;
      offset   <= '0;
    end else if (run_i) begin                                // [RULE_08]
      tick_cnt <= tick ? '0 : tick_cnt + 1'b1;               // [RULE_04]
      if (tick) begin
        half <= ~half;                                       // [RULE_05]
        if (half) begin
          if (dir_up) begin
            if (at_top) dir_up <= 1'b0;                      // [RULE_15]
            else offset <= offset + 7'sd1;
          end else begin
            if (at_bot) dir_up <= 1'b1;                      // [RULE_15]
            else offset <= offset - 7'sd1;
          end
        end
      end
    end
  end

  // the output register freezes with the oscillator in standby
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      trim_o <= FINE_RST;
    else if (run_i)
      trim_o <= next_trim;                                   // [RULE_08]
  end

  fixed_out_a: assert property (  // [RULE_01]
    @(posedge clk_i) disable iff (!rst_n_i)
    (!spread_on && run_i) |=> trim_o == $past(fine_i))
    else $error("trim not fixed with spreading off");
  sweep_value_a: assert property (  // [RULE_03]
    @(posedge clk_i) disable iff (!rst_n_i)
    (spread_on && run_i && !low && !high)
      |=> trim_o == $past(sum[7:0]))
    else $error("swept trim not fine plus offset");
  clamp_hi_a: assert property (  // [RULE_06]
    @(posedge clk_i) disable iff (!rst_n_i)
    (spread_on && run_i && high) |=> trim_o == TRIM_MAX)
    else $error("trim wrapped above range");
  clamp_lo_a: assert property (  // [RULE_06]
    @(posedge clk_i) disable iff (!rst_n_i)
    (spread_on && run_i && low) |=> trim_o == TRIM_MIN)
    else $error("trim wrapped below range");
  update_gap_a: assert property (  // [RULE_04]
    @(posedge clk_i) disable iff (!rst_n_i)
    (tick && rate_i == 4'h2) ##1 (run_i && rate_i == 4'h2)
      |=> (tick || rate_i != 4'h2 || !run_i))
    else $error("update spacing wrong");
  step_one_a: assert property (  // [RULE_15]
    @(posedge clk_i) disable iff (!rst_n_i)
    (tick && half && spread_on)
      |=> (offset - $past(offset) == 7'sd1)
       || ($past(offset) - offset == 7'sd1)
       || (dir_up != $past(dir_up)))
    else $error("offset moved by more than one");
  peak_turn_a: assert property (  // [RULE_02]
    @(posedge clk_i) disable iff (!rst_n_i)
    (tick && half && dir_up && offset == amp_s && spread_on)
      |=> !dir_up && $stable(offset))
    else $error("no reversal at peak");
  halt_hold_a: assert property (  // [RULE_08]
    @(posedge clk_i) disable iff (!rst_n_i)
    (!run_i && spread_on) |=> $stable(trim_o) && $stable(offset))
    else $error("sweep moved in standby");
endmodule : ots_sweep_gen

/* tb/ots_top_tb.sv */
/*
  Self-checking bench for ots_top: register map, band outputs, fixed
  and swept trim, standby freeze and the slow time base.
  Assumes one 50 MHz clock and that the bench drives every port.
*/
`timescale 1ns/1ps
module ots_top_tb import ots_pkg::*;;
  // bench-driven inputs
  logic              clk;
  logic              rst_n;
  logic [ADDR_W-1:0] addr;
  logic              rd_r;
  logic              wr_r;
  logic [31:0]       wdata;
  logic [3:0]        be;
  logic              stby;
  logic              slow_oscillator;
  // observed outputs
  logic [31:0]       rdata;
  logic              wait_r;
  logic [1:0]        band;
  logic              hi;
  logic [7:0]        trim;
  logic              spread;
  logic              run;
  logic [4:0]        strim;
  logic              stb;
  // bookkeeping
  int                err_count;
  int                n_compared;
  logic [31:0]       exp_q[$];
  logic [31:0]       r;
  logic [7:0]        held;

  ots_top DUT (
    .CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(addr),
    .AVS_READ_I(rd_r), .AVS_WRITE_I(wr_r), .AVS_WRITEDATA_I(wdata),
    .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(wait_r), .STANDBY_I(stby),
    .COARSE_BAND_O(band), .HIGH_BAND_O(hi), .SWEPT_TRIM_O(trim),
    .SPREAD_EN_O(spread), .FAST_OSC_RUN_O(run), .SLOW_OSC_I(slow_oscillator),
    .SLOW_TRIM_O(strim), .SLOW_TB_O(stb)
  );

  // 20 ns clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // case equality, so an unknown never passes
  task automatic chk_val(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk_val

  // read data against the oldest queued note
  task automatic chk_rd(input logic [31:0] g);
    if (exp_q.size() == 0) chk_val(32'hFFFFFFFF, g);
    else chk_val(exp_q.pop_front(), g);
  endtask : chk_rd

  // monitor: read data taken at the rising edge that sees wait low
  always @(posedge clk) begin
    if (rd_r === 1'b1 && wait_r === 1'b0) chk_rd(rdata);
  end

  // one bus cycle; request held until a rising edge samples
  // waitrequest low, where the write lands and read data are taken
  task automatic bus(input logic w, input logic [15:0] idx,
                     input logic [31:0] d, input logic [3:0] b);
    int n;
    @(posedge clk);
    addr  <= {idx, 2'b00};
    wdata <= d;
    be    <= b;
    rd_r  <= ~w;
    wr_r  <= w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wait_r !== 1'b0 && n < 50);
    if (n >= 50) err_count++;
    rd_r <= 1'b0;
    wr_r <= 1'b0;
  endtask : bus

  task automatic rd(input logic [15:0] idx, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, idx, 32'h0, 4'h0);
  endtask : rd

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d, 4'hF);
  endtask : wr

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // fixed trim first, then a sweep watched over two full periods
  task automatic sweep(input logic [1:0] ac, input logic [3:0] n,
                       input logic [7:0] f);
    int a, p, lo, hi_e, mn, mx, last, pk0, pk1, t, d;
    logic [7:0] prv;
    a = 4 << ac;
    p = 4 * n * (2 * a + 1);
    lo = (f < a) ? 0 : f - a;
    hi_e = (f + a > 255) ? 255 : f + a;
    wr(IDX_COARSE, 32'h0);
    wr(IDX_FINE, {24'h0, f});
    cyc(3);
    chk_val(f, trim);
    chk_val(32'h0, spread);
    wr(IDX_COARSE, {24'h0, n, ac, 2'b00});
    mn = 255;
    mx = 0;
    last = -100;
    pk0 = -1;
    pk1 = -1;
    prv = trim;
    for (t = 0; t < 2 * p + 2 * n * a + 20; t++) begin
      @(negedge clk);
      if (trim < mn) mn = trim;
      if (trim > mx) mx = trim;
      if (trim != prv) begin
        d = (trim > prv) ? trim - prv : prv - trim;
        chk_val(32'h1, d);
        // updates never come closer than the rate code
        if (t - last < n) chk_val(n, t - last);
        last = t;
        if (trim == hi_e) begin
          pk0 = pk1;
          pk1 = t;
        end
      end
      prv = trim;
    end
    chk_val(lo, mn);
    chk_val(hi_e, mx);
    chk_val(p, pk1 - pk0);
    chk_val(32'h1, spread);
  endtask : sweep

  // 16 slow rising edges must give 8 time-base toggles
  task automatic slow_tb();
    int k, tg;
    logic pv;
    tg = 0;
    pv = stb;
    for (k = 0; k < 132; k++) begin
      @(posedge clk);
      slow_oscillator <= (k % 8) < 4 && k < 128;
      @(negedge clk);
      if (stb !== pv) tg++;
      pv = stb;
    end
    chk_val(32'h8, tg);
  endtask : slow_tb

  task automatic give_verdict();
    if (err_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  // watchdog: the whole run needs well under 40000 cycles
  initial begin
    #(20 * 40000);
    err_count++;
    give_verdict();
  end

  // main sequence
  initial begin
    rst_n = 1'b0;
    addr = '0;
    rd_r = 1'b0;
    wr_r = 1'b0;
    wdata = '0;
    be = '0;
    stby = 1'b0;
    slow_oscillator = 1'b0;
    err_count = 0;
    n_compared = 0;
    r = $urandom(74);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    cyc(1);
    chk_val(FINE_RST, trim);
    chk_val(2'b01, band);
    chk_val(SLOW_RST, strim);
    rd(IDX_COARSE, 32'h01);
    rd(IDX_FINE, 32'h80);
    rd(IDX_SLOW, 32'h10);
    rd(IDX_STATUS, 32'h280);
    // status is read-only: a write to it must change nothing
    wr(IDX_STATUS, 32'hFFFFFFFF);
    rd(IDX_STATUS, 32'h280);
    rd(16'hA000, 32'h0);
    // upper slow trim bits are not kept
    r = $urandom;
    wr(IDX_SLOW, r);
    rd(IDX_SLOW, r & 32'h1F);
    chk_val(r[4:0], strim);
    // a write without byte 0 enabled changes nothing
    bus(1'b1, IDX_FINE, 32'h55, 4'h0);
    rd(IDX_FINE, 32'h80);
    for (int i = 0; i < 4; i++) begin
      r = $urandom;
      r[7:4] = 4'h0;
      r[1:0] = 2'(i);
      wr(IDX_COARSE, r);
      cyc(3);
      chk_val(i, band);
      chk_val(i >> 1, hi);
      rd(IDX_COARSE, r & 32'hFF);
    end
    sweep(2'b00, 4'h3, 8'h02);
    sweep(2'b01, 4'h2, 8'h80);
    sweep(2'b10, 4'h1, 8'h40);
    sweep(2'b11, 4'h4, 8'hF0);
    // standby freezes the running sweep, wake resumes it; the fine
    // trim is re-centred first so the trim is not parked at a clamp
    wr(IDX_FINE, 32'h80);
    @(posedge clk);
    stby <= 1'b1;
    cyc(3);
    chk_val(32'h0, run);
    held = trim;
    cyc(40);
    chk_val(held, trim);
    @(posedge clk);
    stby <= 1'b0;
    cyc(3);
    chk_val(32'h1, run);
    cyc(60);
    chk_val(32'h1, trim != held);
    slow_tb();
    give_verdict();
  end
endmodule : ots_top_tb
